//--- core/dma_adapter.sv
// DMA-capable adapter end of the expansion bus
module dma_adapter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Bus side
  isa_dma_if.adapter bus,
  // User side
  input wire logic [2:0] chan_sel,
  input wire logic xfer_want,
  input wire logic hold_ready,
  input wire logic io_addr_hit,
  output logic io_respond,
  output logic dma_rd_pulse,
  output logic dma_wr_pulse,
  output logic tc_seen,
  output logic granted
);
  import isa_dma_pkg::*;

  typedef struct packed {
    logic [7:0] dack_s1;
    logic [7:0] dack_s2;
    logic [3:0] ctl_s1;
    logic [3:0] ctl_s2;
    logic [1:0] strobe_d;
    logic want;
    logic respond;
    logic rd_p;
    logic wr_p;
    logic tc_p;
    logic granted;
  } adp_state_t;

  adp_state_t s_ff;
  adp_state_t nxt_s;
  logic mine;
  logic aen_s;
  logic tc_s;
  logic ior_s;
  logic iow_s;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.dack_s1 = bus.dack_n;
    nxt_s.dack_s2 = s_ff.dack_s1;
    nxt_s.ctl_s1 = {bus.aen, bus.tc, ~bus.ior_n, ~bus.iow_n};
    nxt_s.ctl_s2 = s_ff.ctl_s1;
    aen_s = s_ff.ctl_s2[3];
    tc_s = s_ff.ctl_s2[2];
    ior_s = s_ff.ctl_s2[1];
    iow_s = s_ff.ctl_s2[0];
    mine = ~s_ff.dack_s2[chan_sel] & CHAN_MASK[chan_sel];
    nxt_s.want = xfer_want & CHAN_MASK[chan_sel];
    nxt_s.granted = mine;
    nxt_s.strobe_d = {ior_s, iow_s};
    nxt_s.rd_p = mine & aen_s & ior_s & ~s_ff.strobe_d[1];
    nxt_s.wr_p = mine & aen_s & iow_s & ~s_ff.strobe_d[0];
    nxt_s.tc_p = mine & tc_s & (ior_s | iow_s) &
                 ~(|s_ff.strobe_d);
    if (aen_s) begin
      nxt_s.respond = mine & (ior_s | iow_s);
    end else begin
      nxt_s.respond = io_addr_hit & (ior_s | iow_s);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '{dack_s1: DACK_IDLE, dack_s2: DACK_IDLE, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************
  // Bus drive
  // ****************************************
  always_comb begin
    bus.drq_out = '0;
    bus.drq_oe = '0;
    bus.drq_out[chan_sel] = s_ff.want;
    bus.drq_oe[chan_sel] = CHAN_MASK[chan_sel];
  end

  assign bus.chrdy_oe = hold_ready & (s_ff.granted | io_addr_hit);
  assign bus.refresh_a_out = 1'b1;
  assign bus.refresh_a_oe = 1'b0;
  assign bus.master_req_out = 1'b1;
  assign bus.master_req_oe = 1'b0;

  assign io_respond = s_ff.respond;
  assign dma_rd_pulse = s_ff.rd_p;
  assign dma_wr_pulse = s_ff.wr_p;
  assign tc_seen = s_ff.tc_p;
  assign granted = s_ff.granted;

endmodule : dma_adapter

//--- core/dma_permanent_master.sv
// Permanent master end: DMA request arbitration and grant
module dma_permanent_master (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Bus side
  isa_dma_if.permanent bus,
  // Channel programming
  input wire logic cnt_load,
  input wire logic [2:0] cnt_chan,
  input wire logic [15:0] cnt_value,
  input wire logic cnt_to_io,
  // Refresh request
  input wire logic refresh_req,
  // Status
  output logic busy,
  output logic [2:0] active_chan,
  output logic active_wide,
  output logic xfer_done,
  output logic tc_done,
  output logic refresh_busy
);
  import isa_dma_pkg::*;

  typedef struct packed {
    logic [7:0] drq_s1;
    logic [7:0] drq_s2;
    logic rdy_s1;
    logic rdy_s2;
    logic [3:0] div;
    logic tick;
    isa_dma_pkg::arb_state_t state;
    logic [2:0] chan;
    logic wide;
    logic [1:0] ticks;
    logic [7:0][15:0] count;
    logic [7:0] to_io;
    logic [7:0] dack_n;
    logic aen;
    logic bale;
    logic tc;
    logic ior_n;
    logic iow_n;
    logic ref_n;
    logic ref_oe;
    logic ref_pend;
    logic done_p;
    logic tc_p;
  } mst_state_t;

  mst_state_t s_ff;
  mst_state_t nxt_s;
  logic [3:0] pick;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] pick_chan(input logic [7:0] req);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req[i] && CHAN_MASK[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : pick_chan

  function automatic mst_state_t release_bus(input mst_state_t s);
    mst_state_t r;
    r = s;
    r.dack_n = DACK_IDLE;
    r.aen = 1'b0;
    r.bale = 1'b0;
    r.tc = 1'b0;
    r.ior_n = 1'b1;
    r.iow_n = 1'b1;
    r.state = ST_IDLE;
    r.wide = 1'b0;
    return r;
  endfunction : release_bus

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.drq_s1 = bus.drq & CHAN_MASK;
    nxt_s.drq_s2 = s_ff.drq_s1;
    nxt_s.rdy_s1 = bus.chrdy;
    nxt_s.rdy_s2 = s_ff.rdy_s1;
    nxt_s.tick = (s_ff.div == BUS_DIV_LAST);
    nxt_s.div = nxt_s.tick ? 4'h0 : s_ff.div + 4'h1;
    nxt_s.done_p = 1'b0;
    nxt_s.tc_p = 1'b0;
    pick = pick_chan(s_ff.drq_s2);
    unique case (s_ff.state)
      ST_IDLE: begin
        if (s_ff.tick && s_ff.ref_pend) begin
          nxt_s.state = ST_REFR;
          nxt_s.ref_oe = 1'b1;
          nxt_s.ref_n = 1'b0;
          nxt_s.bale = 1'b1;
          nxt_s.ticks = 2'h0;
          nxt_s.ref_pend = 1'b0;
        end else if (s_ff.tick && pick[3]) begin
          nxt_s.state = ST_GRANT;
          nxt_s.chan = pick[2:0];
          nxt_s.wide = (pick[2:0] >= FIRST_WIDE_CHAN);
          nxt_s.aen = 1'b1;
          nxt_s.bale = 1'b1;
          nxt_s.dack_n = DACK_IDLE;
          nxt_s.dack_n[pick[2:0]] = 1'b0;
        end
      end
      ST_GRANT: begin
        if (!s_ff.drq_s2[s_ff.chan]) begin
          nxt_s = release_bus(nxt_s);
        end else if (s_ff.tick) begin
          nxt_s.state = ST_CMD;
          nxt_s.ticks = 2'h0;
          nxt_s.iow_n = ~s_ff.to_io[s_ff.chan];
          nxt_s.ior_n = s_ff.to_io[s_ff.chan];
          nxt_s.tc = (s_ff.count[s_ff.chan] == COUNT_RESET);
        end
      end
      ST_CMD: begin
        if (s_ff.tick) begin
          if (s_ff.ticks != CMD_TICKS_LAST) begin
            nxt_s.ticks = s_ff.ticks + 2'h1;
          end else if (s_ff.rdy_s2) begin
            nxt_s.ior_n = 1'b1;
            nxt_s.iow_n = 1'b1;
            nxt_s.tc = 1'b0;
            nxt_s.done_p = 1'b1;
            nxt_s.count[s_ff.chan] = s_ff.count[s_ff.chan] - 16'h1;
            nxt_s.state = ST_RECOV;
            if (s_ff.tc) begin
              nxt_s.tc_p = 1'b1;
              nxt_s = release_bus(nxt_s);
            end
          end
        end
      end
      ST_RECOV: begin
        if (!s_ff.drq_s2[s_ff.chan]) begin
          nxt_s = release_bus(nxt_s);
        end else if (s_ff.tick) begin
          nxt_s.state = ST_GRANT;
        end
      end
      ST_REFR: begin
        if (s_ff.tick) begin
          if (s_ff.ticks != REFRESH_TICKS_LAST) begin
            nxt_s.ticks = s_ff.ticks + 2'h1;
          end else if (s_ff.rdy_s2) begin
            nxt_s.ref_n = 1'b1;
            nxt_s.ref_oe = 1'b0;
            nxt_s.bale = 1'b0;
            nxt_s.state = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_s = release_bus(nxt_s);
      end
    endcase
    if (cnt_load && CHAN_MASK[cnt_chan]) begin
      nxt_s.count[cnt_chan] = cnt_value;
      nxt_s.to_io[cnt_chan] = cnt_to_io;
    end
    if (refresh_req) begin
      nxt_s.ref_pend = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '{state: ST_IDLE, dack_n: DACK_IDLE, ior_n: 1'b1,
                iow_n: 1'b1, ref_n: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.dack_n = s_ff.dack_n;
  assign bus.aen = s_ff.aen;
  assign bus.bale = s_ff.bale;
  assign bus.tc = s_ff.tc;
  assign bus.ior_n = s_ff.ior_n;
  assign bus.iow_n = s_ff.iow_n;
  assign bus.refresh_m_out = s_ff.ref_n;
  assign bus.refresh_m_oe = s_ff.ref_oe;
  // Bus-master request input has no reader:
  // mastership is never handed over

  assign busy = s_ff.aen;
  assign active_chan = s_ff.chan;
  assign active_wide = s_ff.wide;
  assign xfer_done = s_ff.done_p;
  assign tc_done = s_ff.tc_p;
  assign refresh_busy = s_ff.ref_oe;

endmodule : dma_permanent_master

//--- core/isa_dma_if.sv
// Bus wires joining the permanent master and a DMA adapter
interface isa_dma_if;

  // Permanent master drives
  logic [7:0] dack_n;
  logic aen;
  logic bale;
  logic tc;
  logic ior_n;
  logic iow_n;
  logic refresh_m_out;
  logic refresh_m_oe;
  // Adapter drives
  logic [7:0] drq_out;
  logic [7:0] drq_oe;
  logic chrdy_oe;
  logic refresh_a_out;
  logic refresh_a_oe;
  logic master_req_out;
  logic master_req_oe;
  // Resolved wire levels, floating lines pulled to their idle level
  logic [7:0] drq;
  logic chrdy;
  logic refresh_n;
  logic master_req_n;

  assign drq = drq_out & drq_oe;
  assign chrdy = ~chrdy_oe;
  assign refresh_n = ~((refresh_m_oe & ~refresh_m_out) |
                       (refresh_a_oe & ~refresh_a_out));
  assign master_req_n = ~(master_req_oe & ~master_req_out);

  modport permanent (
    input drq, chrdy, refresh_n, master_req_n,
    output dack_n, aen, bale, tc, ior_n, iow_n,
    output refresh_m_out, refresh_m_oe
  );

  modport adapter (
    input dack_n, aen, bale, tc, ior_n, iow_n, refresh_n,
    output drq_out, drq_oe, chrdy_oe, refresh_a_out, refresh_a_oe,
    output master_req_out, master_req_oe
  );

endinterface : isa_dma_if

//--- core/isa_dma_pkg.sv
// Shared constants and types for the expansion bus DMA arbitration ends
// Contract
// - Adapter drives request high only while requesting
// - Channels 0-3 byte, 5-7 word, no 4
// - Adapter request lines are tri-state, unused float
// - Master samples all seven request lines continuously
// - Master asserts low acknowledge to start transfer
// - Acknowledge lines always driven push-pull
// - Address enable high while DMA drives address
// - Address enable high blocks plain I/O decode; adapter still drives ready from io_addr_hit
// - With address enable, only acknowledged adapter responds
// - Current master drives refresh low, tri-state
// - Terminal count high during final transfer command
// - Adapter honours terminal count only when acknowledged
// - Bus-master request line is ignored entirely
// - Adapter uses strobe with acknowledge for direction
// - Latch strobe held high during DMA and refresh
// - Target stretches cycle with open-collector ready
package isa_dma_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CORE_PERIOD_NS = 10;
  localparam int BUS_CYCLE_NS = 120;
  localparam int BUS_DIV = BUS_CYCLE_NS / CORE_PERIOD_NS;
  localparam logic [3:0] BUS_DIV_LAST = 4'(BUS_DIV - 1);
  localparam logic [1:0] CMD_TICKS_LAST = 2'h1;
  localparam logic [1:0] REFRESH_TICKS_LAST = 2'h2;

  // ****************************************
  // Channels
  // ****************************************
  localparam logic [7:0] CHAN_MASK = 8'hef;
  localparam logic [2:0] FIRST_WIDE_CHAN = 3'h5;
  localparam logic [7:0] DACK_IDLE = 8'hff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ****************************************
  // Master states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GRANT = 3'b001,
    ST_CMD = 3'b010,
    ST_RECOV = 3'b011,
    ST_REFR = 3'b100
  } arb_state_t;

endpackage : isa_dma_pkg

//--- verif/isa_dma_assertions.sv
// Concurrent checks on the bus wires between the two ends
module isa_dma_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Bus wires
  input wire logic [7:0] dack_n,
  input wire logic [7:0] drq,
  input wire logic aen,
  input wire logic bale,
  input wire logic tc,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic chrdy,
  input wire logic refresh_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Properties
  // ****************************************
  logic strb;
  assign strb = ~(ior_n & iow_n);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  one_grant_a: assert property ($onehot0(~dack_n))
    else $error("more than one grant");
  chan4_idle_a: assert property (dack_n[4])
    else $error("grant on channel four");
  aen_grant_a: assert property (aen == (dack_n != 8'hff))
    else $error("address enable not tied to grant");
  bale_dma_a: assert property (aen |-> bale)
    else $error("latch strobe low during dma");
  tc_strobe_a: assert property (tc |-> strb)
    else $error("terminal count outside command");
  strobe_aen_a: assert property (strb |-> aen && (ior_n || iow_n))
    else $error("bad command strobe");
  ready_wait_a: assert property (strb && !chrdy && $past(!chrdy) &&
    $past(!chrdy, 2) |=> strb) else $error("cycle ended while not ready");
  grant_request_a: assert property ($rose(aen) |->
    (~dack_n & ($past(drq, 2) | $past(drq, 3) | $past(drq, 4))) != 8'h00)
    else $error("grant without request");
  release_grant_a: assert property
    (aen && (drq & ~dack_n) == 8'h00 |-> ##[0:100] !aen)
    else $error("grant kept after withdrawal");
  refresh_bale_a: assert property (!refresh_n |-> bale && !aen)
    else $error("bad refresh cycle");
endmodule : isa_dma_assertions

//--- verif/test_isa_dma_arbitration_signals.sv
// Self-checking bench joining the permanent master and an adapter
module test_isa_dma_arbitration_signals;
  timeunit 1ns;
  timeprecision 1ps;
  import isa_dma_pkg::*;
  // ****************************************
  // Wiring
  // ****************************************
  logic core_clk, reset_n, cnt_load, cnt_to_io, refresh_req;
  logic xfer_want, hold_ready, io_addr_hit;
  logic [2:0] cnt_chan, chan_sel, active_chan;
  logic [15:0] cnt_value;
  logic busy, active_wide, xfer_done, tc_done, refresh_busy;
  logic io_respond, dma_rd_pulse, dma_wr_pulse, tc_seen, granted;
  int err_count = 0;
  int num_checks = 0;
  int n_rd = 0, n_wr = 0, n_tc = 0, n_td = 0, n_rsp = 0, n_tcd = 0;
  isa_dma_if bus_if ();
  dma_permanent_master i_dma_permanent_master (.core_clk, .reset_n,
    .bus(bus_if), .cnt_load, .cnt_chan, .cnt_value, .cnt_to_io,
    .refresh_req, .busy, .active_chan, .active_wide, .xfer_done,
    .tc_done, .refresh_busy);
  dma_adapter i_dma_adapter (.core_clk, .reset_n, .bus(bus_if),
    .chan_sel, .xfer_want, .hold_ready, .io_addr_hit, .io_respond,
    .dma_rd_pulse, .dma_wr_pulse, .tc_seen, .granted);
  isa_dma_assertions i_isa_dma_assertions (.core_clk, .reset_n,
    .dack_n(bus_if.dack_n), .drq(bus_if.drq), .aen(bus_if.aen),
    .bale(bus_if.bale), .tc(bus_if.tc), .ior_n(bus_if.ior_n),
    .iow_n(bus_if.iow_n), .chrdy(bus_if.chrdy),
    .refresh_n(bus_if.refresh_n));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    n_rd <= n_rd + int'(dma_rd_pulse === 1'b1);
    n_wr <= n_wr + int'(dma_wr_pulse === 1'b1);
    n_tc <= n_tc + int'(tc_seen === 1'b1);
    n_td <= n_td + int'(xfer_done === 1'b1);
    n_rsp <= n_rsp + int'(io_respond === 1'b1);
    n_tcd <= n_tcd + int'(tc_done === 1'b1);
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // Program a channel, request, optionally withdraw after stop transfers
  task automatic xfer(input logic [2:0] c, input logic [15:0] cnt,
                      input logic to_io, input int stop, input int hold);
    int r0, w0, t0, d0, s0, c0, k;
    r0 = n_rd;
    w0 = n_wr;
    t0 = n_tc;
    d0 = n_td;
    s0 = n_rsp;
    c0 = n_tcd;
    chan_sel = c;
    cnt_chan = c;
    cnt_value = cnt;
    cnt_to_io = to_io;
    cnt_load = 1'b1;
    @(negedge core_clk);
    cnt_load = 1'b0;
    xfer_want = 1'b1;
    for (k = 0; k < 100 && granted !== 1'b1; k++) @(negedge core_clk);
    check(bus_if.dack_n, 8'(~(8'h01 << c)));
    check(active_wide, c >= FIRST_WIDE_CHAN);
    check(active_chan, c);
    for (k = 0; k < 2000 && busy === 1'b1; k++) begin
      hold_ready = k < hold;
      if (stop > 0 && n_td - d0 >= stop) xfer_want = 1'b0;
      @(negedge core_clk);
    end
    xfer_want = 1'b0;
    hold_ready = 1'b0;
    check(k > hold, 1'b1);
    repeat (8) @(negedge core_clk);
    check(busy, 1'b0);
    k = stop > 0 ? stop : int'(cnt) + 1;
    check(16'(to_io ? n_wr - w0 : n_rd - r0), 16'(k));
    check(16'(to_io ? n_rd - r0 : n_wr - w0), 16'h0000);
    check(16'(n_tc - t0), 16'(stop == 0));
    check(16'(n_tcd - c0), 16'(stop == 0));
    check(16'(n_td - d0), 16'(k));
    check(n_rsp != s0, 1'b1);
  endtask : xfer
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    int k;
    reset_n = 1'b0;
    cnt_load = 1'b0;
    cnt_chan = 3'h0;
    cnt_value = 16'h0000;
    cnt_to_io = 1'b0;
    refresh_req = 1'b0;
    xfer_want = 1'b0;
    hold_ready = 1'b0;
    io_addr_hit = 1'b1;
    chan_sel = 3'h0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    check(bus_if.dack_n, DACK_IDLE);
    check(bus_if.aen, 1'b0);
    for (int c = 0; c < 8; c++) begin
      if (c != 4) xfer(3'(c), 16'h0001, c[0], 0, 0);
    end
    xfer(3'h5, 16'h0009, 1'b0, 2, 0);
    xfer(3'h2, 16'h0000, 1'b1, 0, 60);
    refresh_req = 1'b1;
    @(negedge core_clk);
    refresh_req = 1'b0;
    for (k = 0; k < 100 && refresh_busy !== 1'b1; k++) @(negedge core_clk);
    @(negedge core_clk);
    check(bus_if.refresh_n, 1'b0);
    check(bus_if.bale, 1'b1);
    for (k = 0; k < 200 && refresh_busy === 1'b1; k++) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
    check(bus_if.refresh_n, 1'b1);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
  end
endmodule : test_isa_dma_arbitration_signals
